//--- hdl/lbd_pkg.sv
// constants, register map and field layout shared by the loop break detector
package lbd_pkg;
    // ======================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SECOND_NS = 1000000000;
    localparam int unsigned TICKS_PER_SEC_DEFAULT = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned TB_COUNT_W = 27;

    // ======================================================
    // widths
    localparam int unsigned PARAM_W = 14;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned MAG_W = 20;
    localparam int unsigned TYPE_W = 4;
    localparam int unsigned ALARM_SLOTS = 3;
    localparam int unsigned IRQ_W = 3;

    // ======================================================
    // register byte addresses
    localparam logic [7:0] ADDR_DETECT_TIME = 8'h00;
    localparam logic [7:0] ADDR_LEVEL = 8'h04;
    localparam logic [7:0] ADDR_BAND = 8'h08;
    localparam logic [7:0] ADDR_ALARM_TYPES = 8'h0c;
    localparam logic [7:0] ADDR_CONFIG = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;

    // ======================================================
    // parameter ranges and reset values (level and band in tenths)
    localparam logic [13:0] TIME_MAX = 14'h270f;
    localparam logic [13:0] TIME_RESET = 14'h0000;
    localparam logic [13:0] LEVEL_MIN = 14'h0001;
    localparam logic [13:0] LEVEL_MAX = 14'h270f;
    localparam logic [13:0] LEVEL_RESET = 14'h0050;
    localparam logic [13:0] BAND_MAX = 14'h270f;
    localparam logic [13:0] BAND_RESET = 14'h001e;
    localparam logic [3:0] LOOP_BREAK_CODE = 4'hc;

    // ======================================================
    // decimal point scaling of tenths into sensor counts
    localparam logic [1:0] DP_ONE = 2'h1;
    localparam logic [1:0] DP_TWO = 2'h2;
    localparam logic [19:0] SCALE_X10 = 20'h0000a;
    localparam logic [19:0] SCALE_X100 = 20'h00064;

    // ======================================================
    // field positions
    localparam int unsigned CFG_DP_LSB = 0;
    localparam int unsigned CFG_HEAT_COOL = 4;
    localparam int unsigned ST_ALARM = 0;
    localparam int unsigned ST_WATCH = 1;
    localparam int unsigned ST_ARMED = 2;
    localparam int unsigned ST_SECS_LSB = 16;
    localparam int unsigned IRQ_RAISED = 0;
    localparam int unsigned IRQ_CLEARED = 1;
    localparam int unsigned IRQ_REFUSED = 2;
endpackage

//--- hdl/sec_timebase.sv
// one-second enable pulse generator with restart
`timescale 1ns/1ps
module sec_timebase #(
    parameter int unsigned TICKS_PER_SEC = lbd_pkg::TICKS_PER_SEC_DEFAULT
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic restart,
    output logic tick
);
    import lbd_pkg::*;

    typedef struct packed {
        logic [TB_COUNT_W-1:0] count;
        logic tick;
    } tb_state_t;

    tb_state_t state;
    tb_state_t next_state;

    localparam logic [TB_COUNT_W-1:0] LAST = TB_COUNT_W'(TICKS_PER_SEC - 1);

    // =========================================
    // counter: restart realigns the second to the caller
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (restart) begin
            next_state.count = '0;
        end else if (state.count == LAST) begin
            next_state.count = '0;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;
endmodule

//--- hdl/loop_break_detector.sv
// loop break alarm monitor with apb register file and interrupt
// Behaviour
// - alarm goes on when deviation exceeds level and fails to shrink by band in the period.
// - with the process value inside the level around the set point, no detection, alarm off.
// - an active alarm clears once the deviation has shrunk by at least the band.
// - shrinking by less than the band within the period still raises the alarm.
// - detection time takes 0 to 9999 seconds and resets to 0.
// - level takes 0.1 to 999.9 units and resets to 8.0.
// - band takes 0.0 to 999.9 units and resets to 3.0.
// - detection works only when an alarm type slot holds code 12.
// - the three parameters are changed only while stopped; writes while running are refused. An autotune result still loads the detection time while running.
// - level and band follow the sensor decimal point, with setting 0 used as setting 1.
// - autotuning loads the detection time unless heating/cooling control is set.
// - no detection while the set point ramps.
// - no detection during autotuning, manual operation or while stopped.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module loop_break_detector #(
    parameter int unsigned TICKS_PER_SEC = lbd_pkg::TICKS_PER_SEC_DEFAULT
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // control core
    input wire logic signed [lbd_pkg::DATA_W-1:0] set_point,
    input wire logic signed [lbd_pkg::DATA_W-1:0] process_value,
    input wire logic run,
    input wire logic sp_ramping,
    input wire logic autotuning,
    input wire logic manual_mode,
    input wire logic at_time_valid,
    input wire logic [lbd_pkg::PARAM_W-1:0] at_time,
    // alarm and interrupt
    output logic loop_break_alarm,
    output logic irq
);
    import lbd_pkg::*;

    typedef struct packed {
        logic [PARAM_W-1:0] detect_time;
        logic [PARAM_W-1:0] level;
        logic [PARAM_W-1:0] band;
        logic [TYPE_W*ALARM_SLOTS-1:0] alarm_types;
        logic [1:0] dp;
        logic heat_cool;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic alarm;
        logic armed;
        logic [MAG_W-1:0] ref_dev;
        logic [PARAM_W-1:0] secs;
        logic [31:0] prdata;
    } lbd_state_t;

    lbd_state_t state;
    lbd_state_t next_state;

    // =========================================
    // helper functions

    // magnitude of set point minus process value
    function automatic logic [MAG_W-1:0] abs_dev(input logic signed [DATA_W-1:0] sp,
                                                 input logic signed [DATA_W-1:0] pv);
        logic signed [DATA_W:0] diff;
        diff = {sp[DATA_W-1], sp} - {pv[DATA_W-1], pv};
        if (diff[DATA_W]) begin
            abs_dev = MAG_W'(-diff);
        end else begin
            abs_dev = MAG_W'(diff);
        end
    endfunction

    // tenths of a unit into sensor counts; setting 0 counts as setting 1
    function automatic logic [MAG_W-1:0] scale_eu(input logic [PARAM_W-1:0] v,
                                                  input logic [1:0] dp);
        logic [MAG_W-1:0] wide;
        wide = MAG_W'(v);
        if (dp <= DP_ONE) begin
            scale_eu = wide;
        end else if (dp == DP_TWO) begin
            scale_eu = MAG_W'(wide * SCALE_X10);
        end else begin
            scale_eu = MAG_W'(wide * SCALE_X100);
        end
    endfunction

    // any slot selecting the loop break type
    function automatic logic type_match(input logic [TYPE_W*ALARM_SLOTS-1:0] types);
        type_match = 1'b0;
        for (int i = 0; i < ALARM_SLOTS; i++) begin
            if (types[i*TYPE_W +: TYPE_W] == LOOP_BREAK_CODE) begin
                type_match = 1'b1;
            end
        end
    endfunction

    // =========================================
    // detection terms
    logic sec_tick;
    logic [MAG_W-1:0] mag;
    logic [MAG_W-1:0] level_s;
    logic [MAG_W-1:0] band_s;
    logic [MAG_W:0] gain;
    logic lb_selected;
    logic enabled;
    logic outside;
    logic watching;
    logic reached;
    logic period_end;
    logic restart;

    always_comb begin
        mag = abs_dev(set_point, process_value);
        level_s = scale_eu(state.level, state.dp);
        band_s = scale_eu(state.band, state.dp);
        gain = {1'b0, state.ref_dev} - {1'b0, mag};
        reached = !gain[MAG_W] && (gain[MAG_W-1:0] >= band_s);
        lb_selected = type_match(state.alarm_types);
        // a zero detection time leaves the monitor idle
        enabled = lb_selected && run && !sp_ramping && !autotuning && !manual_mode
                  && (state.detect_time != '0);
        outside = mag > level_s;
        watching = enabled && outside;
        period_end = watching && state.armed && sec_tick
                     && (PARAM_W'(state.secs + 1'b1) == state.detect_time);
        restart = watching && !state.armed;
    end

    // =========================================
    // seconds timebase, realigned whenever a new period is armed
    sec_timebase #(
        .TICKS_PER_SEC(TICKS_PER_SEC)
    ) u_timebase (
        .clock(clock),
        .rst(rst),
        .restart(restart),
        .tick(sec_tick)
    );

    // =========================================
    // apb decode
    logic setup;
    logic access;
    logic mapped;
    logic is_param;
    logic range_bad;
    logic refused;
    logic [31:0] rd_word;
    logic [PARAM_W-1:0] wr_param;

    always_comb begin
        setup = psel && !penable;
        access = psel && penable;
        wr_param = pwdata[PARAM_W-1:0];
        rd_word = '0;
        mapped = 1'b1;
        is_param = 1'b0;
        range_bad = 1'b0;
        if (paddr == ADDR_DETECT_TIME) begin
            rd_word[PARAM_W-1:0] = state.detect_time;
            is_param = 1'b1;
            range_bad = (pwdata[31:PARAM_W] != '0) || (wr_param > TIME_MAX);
        end else if (paddr == ADDR_LEVEL) begin
            rd_word[PARAM_W-1:0] = state.level;
            is_param = 1'b1;
            range_bad = (pwdata[31:PARAM_W] != '0) || (wr_param < LEVEL_MIN)
                        || (wr_param > LEVEL_MAX);
        end else if (paddr == ADDR_BAND) begin
            rd_word[PARAM_W-1:0] = state.band;
            is_param = 1'b1;
            range_bad = (pwdata[31:PARAM_W] != '0) || (wr_param > BAND_MAX);
        end else if (paddr == ADDR_ALARM_TYPES) begin
            rd_word[TYPE_W*ALARM_SLOTS-1:0] = state.alarm_types;
        end else if (paddr == ADDR_CONFIG) begin
            rd_word[CFG_DP_LSB +: 2] = state.dp;
            rd_word[CFG_HEAT_COOL] = state.heat_cool;
        end else if (paddr == ADDR_STATUS) begin
            rd_word[ST_ALARM] = state.alarm;
            rd_word[ST_WATCH] = watching;
            rd_word[ST_ARMED] = state.armed;
            rd_word[ST_SECS_LSB +: PARAM_W] = state.secs;
        end else if (paddr == ADDR_IRQ_STATUS) begin
            rd_word[IRQ_W-1:0] = state.irq_status;
        end else if (paddr == ADDR_IRQ_MASK) begin
            rd_word[IRQ_W-1:0] = state.irq_mask;
        end else begin
            mapped = 1'b0;
        end
        // parameter writes are refused while the loop runs
        refused = is_param && (run || range_bad);
    end

    // zero wait states; read data was captured during setup
    assign pready = 1'b1;
    assign pslverr = access && (!mapped || (pwrite && refused));

    // =========================================
    // next state
    always_comb begin
        next_state = state;
        // read data sampled in setup so it comes from a flop in access
        if (setup) begin
            next_state.prdata = rd_word;
        end
        // register writes
        if (access && pwrite && mapped) begin
            if (paddr == ADDR_DETECT_TIME && !refused) begin
                next_state.detect_time = wr_param;
            end else if (paddr == ADDR_LEVEL && !refused) begin
                next_state.level = wr_param;
            end else if (paddr == ADDR_BAND && !refused) begin
                next_state.band = wr_param;
            end else if (paddr == ADDR_ALARM_TYPES) begin
                next_state.alarm_types = pwdata[TYPE_W*ALARM_SLOTS-1:0];
            end else if (paddr == ADDR_CONFIG) begin
                next_state.dp = pwdata[CFG_DP_LSB +: 2];
                next_state.heat_cool = pwdata[CFG_HEAT_COOL];
            end else if (paddr == ADDR_IRQ_STATUS) begin
                next_state.irq_status = state.irq_status & ~pwdata[IRQ_W-1:0];
            end else if (paddr == ADDR_IRQ_MASK) begin
                next_state.irq_mask = pwdata[IRQ_W-1:0];
            end
        end
        // autotune result overrides a same-cycle host value
        if (at_time_valid && !state.heat_cool && at_time <= TIME_MAX) begin
            next_state.detect_time = at_time;
        end
        // loop break monitor
        if (!watching) begin
            // suppressed or inside the level: quiet and disarmed
            next_state.alarm = 1'b0;
            next_state.armed = 1'b0;
            next_state.secs = '0;
        end else if (!state.armed) begin
            next_state.armed = 1'b1;
            next_state.ref_dev = mag;
            next_state.secs = '0;
        end else begin
            if (state.alarm && reached) begin
                next_state.alarm = 1'b0;
            end
            if (period_end) begin
                next_state.alarm = !reached;
                next_state.ref_dev = mag;
                next_state.secs = '0;
            end else if (sec_tick) begin
                next_state.secs = PARAM_W'(state.secs + 1'b1);
            end
        end
        // sticky events; a set in the clear cycle wins
        if (next_state.alarm && !state.alarm) begin
            next_state.irq_status[IRQ_RAISED] = 1'b1;
        end
        if (!next_state.alarm && state.alarm) begin
            next_state.irq_status[IRQ_CLEARED] = 1'b1;
        end
        if (access && pwrite && refused) begin
            next_state.irq_status[IRQ_REFUSED] = 1'b1;
        end
    end

    // =========================================
    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= '0;
            state.detect_time <= TIME_RESET;
            state.level <= LEVEL_RESET;
            state.band <= BAND_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign prdata = state.prdata;
    assign loop_break_alarm = state.alarm;
    assign irq = |(state.irq_status & state.irq_mask);

    // =========================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_param_write_running;
        psel && penable && pwrite && run && (paddr == ADDR_DETECT_TIME);
    endsequence

    sequence s_short_period;
        period_end && !reached;
    endsequence

    sequence s_period_met;
        period_end && reached;
    endsequence

    chk_reset_values: assert property ($fell(rst) |-> state.detect_time == TIME_RESET
        && state.level == LEVEL_RESET && state.band == BAND_RESET)
        else $error("parameters not at reset values");
    chk_level_range: assert property (state.level >= LEVEL_MIN && state.level <= LEVEL_MAX)
        else $error("level out of range");
    chk_run_refuse: assert property (s_param_write_running ##0 !at_time_valid
        |-> pslverr ##1 $stable(state.detect_time))
        else $error("detection time changed while running");
    chk_short_alarm: assert property (s_short_period |=> loop_break_alarm)
        else $error("alarm missing after short period");
    chk_band_clear: assert property (watching && state.armed && state.alarm && reached
        |=> !loop_break_alarm)
        else $error("alarm kept after band reached");
    chk_inside_quiet: assert property (enabled && !outside |=> !loop_break_alarm)
        else $error("alarm inside level");
    chk_type_gate: assert property (!lb_selected |=> !loop_break_alarm [*2])
        else $error("alarm without loop break type");
    chk_ramp_quiet: assert property (sp_ramping |=> !loop_break_alarm ##0 !state.armed)
        else $error("detection during ramp");
    chk_mode_quiet: assert property ((autotuning || manual_mode || !run)
        |=> !loop_break_alarm)
        else $error("detection while suppressed");
    chk_autotune_load: assert property (at_time_valid && !state.heat_cool
        && at_time <= TIME_MAX |=> state.detect_time == $past(at_time))
        else $error("autotune time not loaded");
    chk_arm_restart: assert property (watching && !state.armed
        |=> state.armed && state.secs == '0 && state.ref_dev == $past(mag))
        else $error("period not restarted on arm");
    chk_dp_floor: assert property (state.dp <= DP_ONE |-> level_s == MAG_W'(state.level))
        else $error("decimal point floor wrong");

    // period bookkeeping, stored ranges and side effects of a refused write
    chk_period_quiet: assert property (s_period_met |=> !loop_break_alarm)
        else $error("alarm after band reached in period");
    chk_period_restart: assert property (period_end
        |=> state.secs == '0 && state.ref_dev == $past(mag))
        else $error("period end did not restart timer");
    chk_time_range: assert property (state.detect_time <= TIME_MAX)
        else $error("detection time out of range");
    chk_band_range: assert property (state.band <= BAND_MAX)
        else $error("band out of range");
    chk_refuse_flag: assert property (psel && penable && pwrite && refused
        |=> state.irq_status[IRQ_REFUSED] && $stable(state.level) && $stable(state.band))
        else $error("refused write not flagged or not blocked");
endmodule

//--- testbench/ctl_loop_model.sv
// behavioural control loop feeding set point and process value to the detector
`timescale 1ns/1ps
module ctl_loop_model
    import lbd_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // targets from the bench
    input wire logic signed [DATA_W-1:0] sp_target,
    input wire logic signed [DATA_W-1:0] pv_target,
    input wire logic [7:0] slew,
    // loop outputs
    output logic signed [DATA_W-1:0] set_point,
    output logic signed [DATA_W-1:0] process_value
);
    int diff;
    // distance still to travel toward the target
    assign diff = int'(pv_target) - int'(process_value);
    // a real plant moves slowly; slew 0 lets the bench jump for prompt answers
    always_ff @(posedge clock) begin
        if (rst) begin
            set_point <= '0;
            process_value <= '0;
        end else begin
            set_point <= sp_target;
            if (slew == 8'h00 || (diff <= int'(slew) && diff >= -int'(slew))) begin
                process_value <= pv_target;
            end else if (diff > 0) begin
                process_value <= process_value + DATA_W'(slew);
            end else begin
                process_value <= process_value - DATA_W'(slew);
            end
        end
    end
endmodule

//--- testbench/testbench.sv
// self-checking bench for the loop break detector
`timescale 1ns/1ps
module testbench;
    import lbd_pkg::*;
    localparam int TPS = 20;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, alarm, irq;
    logic [7:0] paddr, slew;
    logic [31:0] pwdata, prdata, q, x;
    logic e;
    logic run, ramp, atune, manual, at_valid;
    logic [PARAM_W-1:0] at_time;
    logic signed [DATA_W-1:0] sp_t, pv_t, sp, pv;
    int fail_count, check_count, n;

    ctl_loop_model u_loop (.clock(clock), .rst(rst), .sp_target(sp_t), .pv_target(pv_t),
        .slew(slew), .set_point(sp), .process_value(pv));
    loop_break_detector #(.TICKS_PER_SEC(TPS)) u_dut (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .set_point(sp), .process_value(pv), .run(run),
        .sp_ramping(ramp), .autotuning(atune), .manual_mode(manual),
        .at_time_valid(at_valid), .at_time(at_time), .loop_break_alarm(alarm), .irq(irq));

    // ======================================================
    // helpers
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    task automatic finish_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk(32'h1, 32'h0);
            finish_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(1'b1, a, d);
        chk({31'h0, e}, {31'h0, err});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // bounded wait for the alarm level; n returns cycles spent
    task automatic wait_alarm(input logic lvl, input int bound);
        n = 0;
        while (alarm !== lvl && n < bound) begin
            @(posedge clock);
            n++;
        end
        chk({31'h0, alarm}, {31'h0, lvl});
        if (n >= bound) begin
            finish_test();
        end
    endtask

    task automatic cycles(input int c);
        repeat (c) @(posedge clock);
    endtask

    // ======================================================
    // main sequence
    initial begin
        fail_count = 0;
        check_count = 0;
        x = 32'd28;
        rst = 1'b1;
        {psel, penable, pwrite, run, ramp, atune, manual, at_valid} = '0;
        paddr = '0;
        pwdata = '0;
        at_time = '0;
        sp_t = '0;
        pv_t = '0;
        slew = '0;
        cycles(4);
        rst <= 1'b0;
        rd(ADDR_DETECT_TIME, {18'h0, TIME_RESET});
        rd(ADDR_LEVEL, {18'h0, LEVEL_RESET});
        rd(ADDR_BAND, {18'h0, BAND_RESET});
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(ADDR_DETECT_TIME, 32'd10000, 1'b1);
        wr(ADDR_LEVEL, 32'd0, 1'b1);
        wr(ADDR_BAND, 32'd10000, 1'b1);
        rd(ADDR_DETECT_TIME, 32'h0);
        // loop break code in the middle slot proves a slot other than the first is looked at
        wr(ADDR_ALARM_TYPES, {20'h0, 4'h0, LOOP_BREAK_CODE, 4'h3}, 1'b0);
        wr(ADDR_CONFIG, 32'h1, 1'b0);
        wr(ADDR_DETECT_TIME, 32'd2, 1'b0);
        wr(ADDR_IRQ_MASK, 32'h7, 1'b0);
        run <= 1'b1;
        wr(ADDR_DETECT_TIME, 32'd5, 1'b1);
        rd(ADDR_DETECT_TIME, 32'd2);
        rd(ADDR_IRQ_STATUS, 32'h4);
        wr(ADDR_IRQ_STATUS, 32'h4, 1'b0);
        // deviation of 200 counts held still: alarm after two seconds
        sp_t <= 16'sd1000;
        pv_t <= 16'sd800;
        wait_alarm(1'b1, 200);
        chk({31'h0, n >= 2 * TPS}, 32'h1);
        cycles(2);
        chk({31'h0, irq}, 32'h1);
        wr(ADDR_IRQ_MASK, 32'h0, 1'b0);
        // mask and status land at the access edge, so look one cycle on
        cycles(1);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h7, 1'b0);
        wr(ADDR_IRQ_STATUS, 32'h7, 1'b0);
        cycles(1);
        chk({31'h0, irq}, 32'h0);
        // a jump of 40 counts clears it at once, not at the period end
        pv_t <= 16'sd840;
        wait_alarm(1'b0, 100);
        chk({31'h0, n < 5}, 32'h1);
        // a slow further 10 counts is short of the band
        slew <= 8'h01;
        pv_t <= 16'sd850;
        wait_alarm(1'b1, 200);
        // random deviations inside the level: no detection
        slew <= 8'h00;
        repeat (4) begin
            x = xs(x);
            pv_t <= 16'sd1000 - DATA_W'(x % 81);
            cycles(3);
            chk({31'h0, alarm}, 32'h0);
            cycles(60);
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk({30'h0, q[ST_ALARM], q[ST_WATCH]}, 32'h0);
        end
        // 85 counts is outside 8.0 at one digit, inside it at two
        pv_t <= 16'sd915;
        wr(ADDR_CONFIG, 32'h0, 1'b0);
        cycles(3);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, q[ST_WATCH]}, 32'h1);
        wr(ADDR_CONFIG, {30'h0, DP_TWO}, 1'b0);
        cycles(3);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, q[ST_WATCH]}, 32'h0);
        wr(ADDR_CONFIG, 32'h1, 1'b0);
        // each suppressing condition in turn, deviation large
        pv_t <= 16'sd800;
        for (int k = 0; k < 5; k++) begin
            if (k == 0) begin
                wr(ADDR_ALARM_TYPES, 32'h123, 1'b0);
            end
            ramp <= (k == 1);
            atune <= (k == 2);
            manual <= (k == 3);
            run <= (k != 4);
            cycles(3 * TPS + 10);
            chk({31'h0, alarm}, 32'h0);
            wr(ADDR_ALARM_TYPES, {24'h0, LOOP_BREAK_CODE, 4'h0}, 1'b0);
        end
        run <= 1'b0;
        // autotune delivers a time unless heating/cooling is set
        at_time <= 14'd7;
        at_valid <= 1'b1;
        cycles(1);
        at_valid <= 1'b0;
        rd(ADDR_DETECT_TIME, 32'd7);
        wr(ADDR_CONFIG, 32'h11, 1'b0);
        at_time <= 14'd9;
        at_valid <= 1'b1;
        cycles(1);
        at_valid <= 1'b0;
        rd(ADDR_DETECT_TIME, 32'd7);
        finish_test();
    end
endmodule
